/* File: design/sgc_top.sv */
// Switchgear command supervision and wear monitor with an AXI4-Lite register slave.
`timescale 1ns/1ps
module sgc_top
  import sgc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic panel_close,
  input wire logic panel_open,
  input wire logic remote_close,
  input wire logic remote_open,
  input wire logic prot_trip,
  input wire logic sync_release,
  input wire logic interlock_close,
  input wire logic interlock_open,
  input wire logic bypass_ext,
  input wire logic aux_closed,
  input wire logic [15:0] trip_current_l1,
  input wire logic [15:0] trip_current_l2,
  input wire logic [15:0] trip_current_l3,
  output logic close_cmd,
  output logic open_cmd,
  output logic position_manipulated,
  output logic operations_alarm,
  output logic isum_alarm,
  output logic [2:0] isum_phase_alarm,
  output logic hourly_interrupt_alarm,
  output logic slow_operation_alarm,
  output logic wear_curve_alarm,
  output logic sync_fail,
  output logic [1:0] interlock_bypass_mode
);
  import sgc_pkg::*;

  // Pin inputs pass two flip-flops; stage one feeds stage two only.
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_meta, pin_sync;
  wire [NPIN-1:0] pin_raw = {panel_close, panel_open, remote_close, remote_open, prot_trip,
                             sync_release, interlock_close, interlock_open, bypass_ext, aux_closed};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end
  wire s_pclose = pin_sync[9];
  wire s_popen = pin_sync[8];
  wire s_rclose = pin_sync[7];
  wire s_ropen = pin_sync[6];
  wire s_trip = pin_sync[5];
  wire s_sync = pin_sync[4];
  wire s_ilk_c = pin_sync[3];
  wire s_ilk_o = pin_sync[2];
  wire s_byp_ext = pin_sync[1];
  wire s_aux = pin_sync[0];

  // Registers.
  logic [31:0] ctrl, sync_time, byp_time, ops_max, isum_max, hour_max, move_on, move_off;
  logic [31:0] ops_cnt, hour_sum, mv_cnt, tmr, byp_cnt, sec_cnt;
  logic [31:0] isum [3];
  logic [31:0] curve [CURVE_POINTS];
  logic [11:0] hour_cnt;
  logic [6:0] capacity;
  logic [1:0] sw_cmd;
  logic pclose_q, single_armed, byp_timed_on;
  sgc_state_t state;

  // AXI4-Lite write: address and data taken in either order, response after both.
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return old;
  endfunction
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction
  wire wr_curve = aw_addr >= ADDR_CURVE && aw_addr < ADDR_CURVE_END;
  wire [3:0] wr_idx = 4'((aw_addr - ADDR_CURVE) >> 2);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_bresp = 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      sync_time <= TIME_RESET;
      byp_time <= TIME_RESET;
      ops_max <= LIMIT_RESET;
      isum_max <= LIMIT_RESET;
      hour_max <= LIMIT_RESET;
      move_on <= TIME_RESET;
      move_off <= TIME_RESET;
      for (int i = 0; i < CURVE_POINTS; i++) begin
        curve[i] <= 32'h0000_0000;
      end
    end else if (do_write) begin
      if (hit(aw_addr, ADDR_CTRL)) ctrl <= merge(ctrl, w_data, w_strb);
      if (hit(aw_addr, ADDR_SYNC_TIME)) sync_time <= merge(sync_time, w_data, w_strb);
      if (hit(aw_addr, ADDR_BYP_TIME)) byp_time <= merge(byp_time, w_data, w_strb);
      if (hit(aw_addr, ADDR_OPS_MAX)) ops_max <= merge(ops_max, w_data, w_strb);
      if (hit(aw_addr, ADDR_ISUM_MAX)) isum_max <= merge(isum_max, w_data, w_strb);
      if (hit(aw_addr, ADDR_HOUR_MAX)) hour_max <= merge(hour_max, w_data, w_strb);
      if (hit(aw_addr, ADDR_MOVE_ON)) move_on <= merge(move_on, w_data, w_strb);
      if (hit(aw_addr, ADDR_MOVE_OFF)) move_off <= merge(move_off, w_data, w_strb);
      if (wr_curve) curve[wr_idx] <= merge(curve[wr_idx], w_data, w_strb);
    end
  end
  // A write to the command register is a one-cycle software request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_cmd <= 2'h0;
    end else begin
      sw_cmd <= (do_write && hit(aw_addr, ADDR_CMD) && w_strb[0]) ? w_data[1:0] : 2'h0;
    end
  end

  // Control decode.
  wire [1:0] auth = ctrl[CTRL_AUTH_LSB +: 2];
  assign interlock_bypass_mode = ctrl[CTRL_BYP_LSB +: 2];
  wire sync_assigned = ctrl[CTRL_SYNC_EN];
  wire position_closed = ctrl[CTRL_MANIP_EN] ? ctrl[CTRL_MANIP_POS] : s_aux;
  assign position_manipulated = ctrl[CTRL_MANIP_EN];
  wire local_ok = auth == AUTH_LOCAL || auth == AUTH_BOTH;
  wire remote_ok = auth == AUTH_REMOTE || auth == AUTH_BOTH;
  // The panel close acts on its rising edge only, so a held key cannot pump the breaker.
  wire panel_close_edge = s_pclose && !pclose_q;
  wire req_close = (local_ok && panel_close_edge) || (remote_ok && (s_rclose || sw_cmd[CMD_CLOSE]));
  wire req_open = (local_ok && s_popen) || (remote_ok && (s_ropen || sw_cmd[CMD_OPEN]));
  wire bypass_on = interlock_bypass_mode == BYP_PERM || byp_timed_on || single_armed || s_byp_ext;
  wire close_ok = req_close && !position_closed && (bypass_on || !s_ilk_c);
  wire open_ok = req_open && position_closed && (bypass_on || !s_ilk_o);
  wire sync_ok = !sync_assigned || s_sync;
  wire idle = state == ST_IDLE;

  // Sequencer: the trip path bypasses authority, interlocks and the busy check.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      tmr <= 32'h0000_0000;
      close_cmd <= 1'b0;
      open_cmd <= 1'b0;
      sync_fail <= 1'b0;
      pclose_q <= 1'b0;
    end else begin
      pclose_q <= s_pclose;
      sync_fail <= 1'b0;
      open_cmd <= s_trip || state == ST_OPEN;
      close_cmd <= state == ST_CLOSE && !s_trip;
      case (state)
        ST_IDLE: begin
          tmr <= 32'h0000_0000;
          if (open_ok) begin
            state <= ST_OPEN;
          end else if (close_ok) begin
            state <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          tmr <= tmr + 32'h0000_0001;
          if (sync_ok) begin
            state <= ST_CLOSE;
          end else if (tmr >= sync_time) begin
            state <= ST_IDLE;
            sync_fail <= 1'b1;
          end
        end
        ST_CLOSE: state <= ST_DONE;
        ST_OPEN: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Bypass timer and single-operation arming.
  wire cmd_taken = idle && (open_ok || close_ok);
  logic [1:0] mode_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= BYP_OFF;
      byp_cnt <= 32'h0000_0000;
      single_armed <= 1'b0;
      byp_timed_on <= 1'b0;
    end else begin
      mode_q <= interlock_bypass_mode;
      if (interlock_bypass_mode != mode_q) begin
        byp_cnt <= 32'h0000_0000;
        single_armed <= interlock_bypass_mode == BYP_SINGLE;
        byp_timed_on <= interlock_bypass_mode == BYP_TIMED;
      end else if (single_armed || byp_timed_on) begin
        byp_cnt <= byp_cnt + 32'h0000_0001;
        if (byp_cnt >= byp_time) begin
          single_armed <= 1'b0;
          byp_timed_on <= 1'b0;
        end else if (cmd_taken && single_armed) begin
          single_armed <= 1'b0;
        end
      end
    end
  end

  // Wear monitoring: counts, current sums, travel time and the curve.
  logic open_q, moving, move_dir_close, pos_q;
  wire [31:0] cur [3] = '{32'(trip_current_l1), 32'(trip_current_l2), 32'(trip_current_l3)};
  wire [31:0] max_i = (cur[0] > cur[1]) ? ((cur[0] > cur[2]) ? cur[0] : cur[2]) : ((cur[1] > cur[2]) ? cur[1] : cur[2]);
  wire [3:0] last_pt = (ctrl[CTRL_CURVE_N_LSB +: 4] == 4'h0) ? 4'h0 : ctrl[CTRL_CURVE_N_LSB +: 4] - 4'h1;
  // Curve point: current in kA in bits 31:16, allowed operations in bits 15:0.
  logic [31:0] allowed;
  always_comb begin
    allowed = 32'h0000_0000;
    for (int i = CURVE_POINTS - 2; i >= 0; i--) begin
      if (4'(i) < last_pt && max_i >= 32'(curve[i][31:16]) && max_i <= 32'(curve[i+1][31:16])) begin
        allowed = 32'(curve[i][15:0]) - 32'((32'(curve[i][15:0]) - ((4'(i + 1) == last_pt) ? 32'h0 : 32'(curve[i+1][15:0])))
          * (max_i - 32'(curve[i][31:16])) / ((curve[i+1][31:16] == curve[i][31:16]) ? 32'h1 :
          32'(curve[i+1][31:16] - curve[i][31:16])));
      end
    end
    if (max_i < 32'(curve[0][31:16])) allowed = 32'(curve[0][15:0]);
  end
  logic [31:0] wear_used;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_q <= 1'b0;
      pos_q <= 1'b0;
      ops_cnt <= 32'h0000_0000;
      for (int p = 0; p < 3; p++) isum[p] <= 32'h0000_0000;
      hour_sum <= 32'h0000_0000;
      sec_cnt <= 32'h0000_0000;
      hour_cnt <= 12'h000;
      moving <= 1'b0;
      move_dir_close <= 1'b0;
      mv_cnt <= 32'h0000_0000;
      slow_operation_alarm <= 1'b0;
      wear_used <= 32'h0000_0000;
      wear_curve_alarm <= 1'b0;
      capacity <= 7'h00;
    end else begin
      open_q <= open_cmd;
      pos_q <= position_closed;
      if ((open_cmd && !open_q) || close_cmd) begin
        ops_cnt <= ops_cnt + 32'h0000_0001;
        moving <= 1'b1;
        move_dir_close <= close_cmd;
        mv_cnt <= 32'h0000_0000;
      end else if (moving) begin
        mv_cnt <= mv_cnt + 32'h0000_0001;
        if (position_closed == move_dir_close) begin
          moving <= 1'b0;
          if (mv_cnt > (move_dir_close ? move_on : move_off)) slow_operation_alarm <= 1'b1;
        end
      end
      if (open_cmd && !open_q) begin
        for (int p = 0; p < 3; p++) isum[p] <= isum[p] + cur[p];
        hour_sum <= hour_sum + max_i;
        if (allowed == 32'h0000_0000) wear_curve_alarm <= 1'b1;
        else wear_used <= wear_used + (32'd100 / allowed) + 32'h1;
      end
      if (wear_used >= 32'(CAPACITY_FULL)) begin
        capacity <= 7'(CAPACITY_FULL);
        wear_curve_alarm <= 1'b1;
      end else begin
        capacity <= wear_used[6:0];
      end
      sec_cnt <= (sec_cnt >= 32'(SEC_CYCLES - 1)) ? 32'h0 : sec_cnt + 32'h1;
      if (sec_cnt >= 32'(SEC_CYCLES - 1)) begin
        hour_cnt <= (hour_cnt >= 12'(HOUR_S - 1)) ? 12'h000 : hour_cnt + 12'h001;
        if (hour_cnt >= 12'(HOUR_S - 1)) hour_sum <= 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operations_alarm <= 1'b0;
      isum_alarm <= 1'b0;
      isum_phase_alarm <= 3'h0;
      hourly_interrupt_alarm <= 1'b0;
    end else begin
      operations_alarm <= ops_cnt > ops_max;
      for (int p = 0; p < 3; p++) isum_phase_alarm[p] <= isum[p] > isum_max;
      isum_alarm <= isum[0] > isum_max || isum[1] > isum_max || isum[2] > isum_max;
      hourly_interrupt_alarm <= hour_sum > hour_max;
    end
  end

  // AXI4-Lite read, one cycle after the address is taken.
  wire [7:0] ra = s_axi_araddr;
  wire rd_curve = ra >= ADDR_CURVE && ra < ADDR_CURVE_END;
  wire [3:0] rd_idx = 4'((ra - ADDR_CURVE) >> 2);
  wire [31:0] status = {21'h0, state == ST_IDLE, sync_fail, wear_curve_alarm, slow_operation_alarm,
                        hourly_interrupt_alarm, isum_phase_alarm, isum_alarm, operations_alarm, position_closed};
  wire [31:0] rd_val = hit(ra, ADDR_CTRL) ? ctrl : hit(ra, ADDR_SYNC_TIME) ? sync_time :
    hit(ra, ADDR_BYP_TIME) ? byp_time : hit(ra, ADDR_OPS_MAX) ? ops_max : hit(ra, ADDR_ISUM_MAX) ? isum_max :
    hit(ra, ADDR_HOUR_MAX) ? hour_max : hit(ra, ADDR_MOVE_ON) ? move_on : hit(ra, ADDR_MOVE_OFF) ? move_off :
    hit(ra, ADDR_STATUS) ? status : hit(ra, ADDR_OPS_CNT) ? ops_cnt : hit(ra, ADDR_ISUM1) ? isum[0] :
    hit(ra, ADDR_ISUM2) ? isum[1] : hit(ra, ADDR_ISUM3) ? isum[2] : hit(ra, ADDR_CAPACITY) ? 32'(capacity) :
    hit(ra, ADDR_HOUR_SUM) ? hour_sum : rd_curve ? curve[rd_idx] : 32'h0000_0000;
  wire rd_map = rd_curve || ra <= ADDR_HOUR_SUM;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  a_close_needs_sync: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_SYNC && !sync_ok && tmr < sync_time) |=> state != ST_CLOSE)
    else $error("close left sync wait without release");
  a_sync_timeout_free: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sync_fail) |-> $past(state) == ST_SYNC && state == ST_IDLE)
    else $error("sync timeout did not free the sequencer");
  a_none_blocks_close: assert property (@(posedge aclk) disable iff (!aresetn)
    (auth == AUTH_NONE && idle) |=> state != ST_SYNC)
    else $error("command accepted with authority none");
  a_trip_always_opens: assert property (@(posedge aclk) disable iff (!aresetn)
    s_trip |=> open_cmd)
    else $error("protection trip suppressed");
  a_busy_ignores_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_CLOSE) |=> state == ST_DONE ##1 state == ST_IDLE)
    else $error("sequencer overlap");
  a_no_double_close: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle && position_closed && !open_ok) |=> state != ST_SYNC)
    else $error("close issued while closed");
  a_single_lapse: assert property (@(posedge aclk) disable iff (!aresetn)
    (single_armed && interlock_bypass_mode == mode_q && cmd_taken) |=> !single_armed)
    else $error("single bypass not consumed");
  a_ops_alarm: assert property (@(posedge aclk) disable iff (!aresetn)
    (ops_cnt > ops_max) |=> operations_alarm)
    else $error("operation alarm missing");
  c_close_done: cover property (@(posedge aclk) disable iff (!aresetn) state == ST_CLOSE);
  c_sync_fail: cover property (@(posedge aclk) disable iff (!aresetn) sync_fail);
  c_slow: cover property (@(posedge aclk) disable iff (!aresetn) $rose(slow_operation_alarm));
endmodule

/* File: inc/sgc_pkg.sv */
// Package with register map, field positions, reset values and timing counts for the switchgear command control.
package sgc_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_SYNC_TIME = 8'h08;
  localparam logic [7:0] ADDR_BYP_TIME = 8'h0c;
  localparam logic [7:0] ADDR_OPS_MAX = 8'h10;
  localparam logic [7:0] ADDR_ISUM_MAX = 8'h14;
  localparam logic [7:0] ADDR_HOUR_MAX = 8'h18;
  localparam logic [7:0] ADDR_MOVE_ON = 8'h1c;
  localparam logic [7:0] ADDR_MOVE_OFF = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_OPS_CNT = 8'h28;
  localparam logic [7:0] ADDR_ISUM1 = 8'h2c;
  localparam logic [7:0] ADDR_ISUM2 = 8'h30;
  localparam logic [7:0] ADDR_ISUM3 = 8'h34;
  localparam logic [7:0] ADDR_CAPACITY = 8'h38;
  localparam logic [7:0] ADDR_HOUR_SUM = 8'h3c;
  localparam logic [7:0] ADDR_CURVE = 8'h40;
  localparam logic [7:0] ADDR_CURVE_END = 8'h68;
  // Control register field positions.
  localparam int CTRL_AUTH_LSB = 0;
  localparam int CTRL_BYP_LSB = 2;
  localparam int CTRL_SYNC_EN = 4;
  localparam int CTRL_MANIP_EN = 5;
  localparam int CTRL_MANIP_POS = 6;
  localparam int CTRL_CURVE_N_LSB = 8;
  // Command register bits: software sourced close and open.
  localparam int CMD_CLOSE = 0;
  localparam int CMD_OPEN = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TIME_RESET = 32'h0000_03e8;
  localparam logic [31:0] LIMIT_RESET = 32'hffff_ffff;
  localparam int CURVE_POINTS = 10;
  // One hour in seconds and the cycles per second at 50 MHz.
  localparam int HOUR_S = 3600;
  localparam int CLK_HZ = 50000000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int CAPACITY_FULL = 100;
  typedef enum logic [1:0] {AUTH_NONE = 2'h0, AUTH_LOCAL = 2'h1, AUTH_REMOTE = 2'h2, AUTH_BOTH = 2'h3} sgc_auth_t;
  typedef enum logic [1:0] {BYP_OFF = 2'h0, BYP_SINGLE = 2'h1, BYP_PERM = 2'h2, BYP_TIMED = 2'h3} sgc_byp_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SYNC = 5'h02,
    ST_CLOSE = 5'h04,
    ST_OPEN = 5'h08,
    ST_DONE = 5'h10
  } sgc_state_t;
endpackage

/* File: tb/sgc_breaker_model.sv */
// Behavioural breaker with a closed auxiliary contact that follows commands after a travel delay.
`timescale 1ns/1ps
module sgc_breaker_model #(
  parameter int MOVE = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic close_cmd,
  input wire logic open_cmd,
  output logic aux_closed
);
  int cnt;
  logic tgt;
  // Open wins over close, as a tripping breaker would.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aux_closed <= 1'b0;
      tgt <= 1'b0;
      cnt <= 0;
    end else if (open_cmd) begin
      tgt <= 1'b0;
      cnt <= MOVE;
    end else if (close_cmd) begin
      tgt <= 1'b1;
      cnt <= MOVE;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      aux_closed <= tgt;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the switchgear command control block.
`timescale 1ns/1ps
module tb_top;
  import sgc_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, aux;
  logic [1:0] bresp, rresp, rd_r, il = 0;
  logic [4:0] keys = 0;
  logic sync_rel = 0, byp_ext = 0;
  logic [15:0] cur = 16'h0010;
  logic close_cmd, open_cmd, manip, ops_alm, sync_fail, pc = 0, po = 0, ps = 0;
  int n_close = 0, n_open = 0, n_sync = 0, miscompares = 0, n_tests = 0, cyc = 0;
  always #10 aclk = ~aclk;
  sgc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .panel_close(keys[0]), .panel_open(keys[1]), .remote_close(keys[2]),
    .remote_open(keys[3]), .prot_trip(keys[4]), .sync_release(sync_rel), .interlock_close(il[0]),
    .interlock_open(il[1]), .bypass_ext(byp_ext), .aux_closed(aux), .trip_current_l1(cur),
    .trip_current_l2(cur), .trip_current_l3(cur), .close_cmd(close_cmd), .open_cmd(open_cmd),
    .position_manipulated(manip), .operations_alarm(ops_alm), .isum_alarm(), .isum_phase_alarm(),
    .hourly_interrupt_alarm(), .slow_operation_alarm(), .wear_curve_alarm(), .sync_fail(sync_fail),
    .interlock_bypass_mode());
  sgc_breaker_model #(.MOVE(5)) sg (.aclk(aclk), .aresetn(aresetn), .close_cmd(close_cmd),
    .open_cmd(open_cmd), .aux_closed(aux));
  // Count rising edges so a long trip level still counts once.
  always @(posedge aclk) begin
    if (close_cmd === 1'b1 && pc !== 1'b1) n_close <= n_close + 1;
    if (open_cmd === 1'b1 && po !== 1'b1) n_open <= n_open + 1;
    if (sync_fail === 1'b1 && ps !== 1'b1) n_sync <= n_sync + 1;
    pc <= close_cmd;
    po <= open_cmd;
    ps <= sync_fail;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Holding a key for many cycles also exercises the one-pulse-per-press behaviour.
  task automatic press(input logic [4:0] k);
    keys <= k;
    // Remote commands are levels that an idle sequencer takes again, so they are sent as short pulses.
    repeat ((k[3:2] != 2'b00) ? 2 : 30) @(posedge aclk);
    keys <= 5'h00;
    repeat (30) @(posedge aclk);
  endtask
  task automatic cnt(input int c, input int o);
    chk("close pulses", n_close, c);
    chk("open pulses", n_open, o);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL); chk("ctrl reset", rd_v, CTRL_RESET);
    rd(ADDR_SYNC_TIME); chk("sync time reset", rd_v, TIME_RESET);
    rd(ADDR_OPS_MAX); chk("ops max reset", rd_v, LIMIT_RESET);
    rd(8'h80); chk("unmapped resp", {30'h0, rd_r}, 32'h2);
    press(5'h01); press(5'h04); cnt(0, 0);
    wr(ADDR_CTRL, 32'h1);
    press(5'h04); cnt(0, 0);
    press(5'h01); cnt(1, 0);
    press(5'h01); cnt(1, 0);
    wr(ADDR_CTRL, 32'h2);
    press(5'h02); cnt(1, 0);
    press(5'h08); cnt(1, 1);
    wr(ADDR_CTRL, 32'h3);
    press(5'h01); cnt(2, 1);
    wr(ADDR_CTRL, 32'h0);
    press(5'h10); cnt(2, 2);
    wr(ADDR_SYNC_TIME, 32'h8);
    wr(ADDR_CTRL, 32'h13);
    press(5'h04); cnt(2, 2);
    chk("sync fail", n_sync, 1);
    sync_rel <= 1'b1;
    press(5'h04); cnt(3, 2);
    sync_rel <= 1'b0;
    il <= 2'b11;
    wr(ADDR_CTRL, 32'h3);
    press(5'h08); cnt(3, 2);
    wr(ADDR_CTRL, 32'h7);
    press(5'h08); cnt(3, 3);
    press(5'h04); cnt(3, 3);
    il <= 2'b00;
    chk("ops alarm low", ops_alm, 0);
    wr(ADDR_OPS_MAX, 32'h0);
    repeat (4) @(posedge aclk);
    chk("ops alarm", ops_alm, 1);
    wr(ADDR_CTRL, 32'h63);
    repeat (4) @(posedge aclk);
    chk("manipulated", manip, 1);
    rd(ADDR_STATUS); chk("manip position", rd_v[0], 1);
    rd(ADDR_OPS_CNT); chk("ops count", rd_v, 6);
    end_sim();
  end
endmodule
